// ==== pkg/lsf_map.svh ====
`ifndef LSF_MAP_SVH
`define LSF_MAP_SVH

// Frame geometry
`define LSF_FRAME_LEN     194
`define LSF_FRAME_MSB     193
`define LSF_CH            16
`define LSF_GS_W          12
`define LSF_DC_W          6
`define LSF_FLT_W         16
// Input frame fields
`define LSF_BIT_LIGHT     193
`define LSF_BIT_TYPE      192
`define LSF_DC_FIELD_MSB  95
// Status frame fields
`define LSF_ST_OT_BIT     193
`define LSF_ST_FLT_MSB    192
`define LSF_ST_FLT_LSB    177

// Register byte addresses
`define LSF_ADR_CTRL      8'h00
`define LSF_ADR_STATE     8'h04
`define LSF_ADR_IRQ_STAT  8'h08
`define LSF_ADR_IRQ_MASK  8'h0C
`define LSF_PAGE_GS       2'b01
`define LSF_PAGE_DC       2'b10
// State register fields
`define LSF_ST_R_OT       16
`define LSF_ST_R_TYPE     17
`define LSF_ST_R_LIGHT    18
`define LSF_ST_R_BLOCK    19
// Control register fields and reset
`define LSF_CTRL_SOFT_POR 0
`define LSF_CTRL_RST      1'b0
// Interrupt events
`define LSF_EV_W          3
`define LSF_EV_GS         0
`define LSF_EV_DC         1
`define LSF_EV_FAULT      2
`define LSF_MASK_RST      3'h0

// Synchroniser width: por, ot, faults, latch, clock, data
`define LSF_SYNC_W        21

`endif

// ==== pkg/lsf_pkg.sv ====
package lsf_pkg;
`include "lsf_map.svh"
   typedef logic [`LSF_GS_W-1:0]      lsf_gs_t;
   typedef logic [`LSF_DC_W-1:0]      lsf_dc_t;
   typedef logic [`LSF_FRAME_MSB:0]   lsf_frame_t;
   typedef logic [`LSF_EV_W-1:0]      lsf_ev_t;
endpackage

// ==== hw/lsf_sync.sv ====
`timescale 1ns/100ps
module lsf_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Asynchronous inputs
   input  wire logic [W-1:0] d_i,
   // Synchronised level and one-cycle-late copy
   output logic      [W-1:0] q_o,
   output logic      [W-1:0] q_dly_o
);
   logic [W-1:0] meta;

   // Two-stage synchroniser plus history stage for edge detection
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta    <= '0;
         q_o     <= '0;
         q_dly_o <= '0;
      end else begin
         meta    <= d_i;
         q_o     <= meta;
         q_dly_o <= q_o;
      end
   end
endmodule

// ==== hw/lsf_irq.sv ====
`timescale 1ns/100ps
`include "lsf_map.svh"
module lsf_irq (
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // Events, mask and clear
   input  wire logic [`LSF_EV_W-1:0] event_i,
   input  wire logic [`LSF_EV_W-1:0] mask_i,
   input  wire logic [`LSF_EV_W-1:0] clear_i,
   // Sticky status and level interrupt
   output logic      [`LSF_EV_W-1:0] status_o,
   output logic                      irq_o
);
   // Sticky bits, a new event beats a clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_o <= '0;
      end else begin
         status_o <= (status_o & ~clear_i) | event_i;
      end
   end

   // Level interrupt while any unmasked bit is set
   assign irq_o = |(status_o & mask_i);
endmodule

// ==== hw/lsf_frame_port.sv ====
`timescale 1ns/100ps
`include "lsf_map.svh"
module lsf_frame_port (
   // Clock and reset
   input  wire logic                               clk_i,
   input  wire logic                               rst_i,
   // Wishbone slave
   input  wire logic                               wb_cyc_i,
   input  wire logic                               wb_stb_i,
   input  wire logic                               wb_we_i,
   input  wire logic [7:0]                         wb_adr_i,
   input  wire logic [3:0]                         wb_sel_i,
   input  wire logic [31:0]                        wb_dat_i,
   output logic      [31:0]                        wb_dat_o,
   output logic                                    wb_ack_o,
   output logic                                    irq_o,
   // Serial link inputs
   input  wire logic                               latch_in_i,
   input  wire logic                               shift_clock_in_i,
   input  wire logic                               serial_in_i,
   // Serial link outputs to the next chip
   output logic                                    latch_out_o,
   output logic                                    shift_clock_out_o,
   output logic                                    serial_out_o,
   // Analog side
   input  wire logic                               por_i,
   input  wire logic                               overheat_flag_i,
   input  wire logic [`LSF_FLT_W-1:0]              channel_fault_flags_i,
   // Settings to the current sinks
   output logic                                    frame_type_reg_o,
   output logic                                    light_all_o,
   output logic      [`LSF_CH*`LSF_GS_W-1:0]       grayscale_level_o,
   output logic      [`LSF_CH*`LSF_DC_W-1:0]       dot_correction_o
);
   logic [`LSF_SYNC_W-1:0]  sync_q;
   logic [`LSF_SYNC_W-1:0]  sync_d;
   logic                    por_s2,  por_s3;
   logic                    ot_s2,   ot_s3;
   logic [`LSF_FLT_W-1:0]   flt_s2,  flt_s3;
   logic                    ld_s2,   ld_s3;
   logic                    ck_s2,   ck_s3;
   logic                    sd_s2,   sd_s3;
   logic                    soft_por;
   logic                    blocked;
   logic                    core_rst;
   logic                    ck_rise;
   logic                    ld_rise;
   lsf_pkg::lsf_frame_t     chain;
   lsf_pkg::lsf_gs_t        gs_q [`LSF_CH];
   lsf_pkg::lsf_dc_t        dc_q [`LSF_CH];
   lsf_pkg::lsf_ev_t        events;
   lsf_pkg::lsf_ev_t        irq_mask;
   lsf_pkg::lsf_ev_t        irq_status;
   lsf_pkg::lsf_ev_t        irq_clear;
   logic                    wb_hit;
   logic                    wb_wr;
   logic [31:0]             rd_word;

   // Grayscale field of one channel in an input frame
   function automatic lsf_pkg::lsf_gs_t gs_field(input lsf_pkg::lsf_frame_t f, input int ch);
      return f[ch*`LSF_GS_W +: `LSF_GS_W];
   endfunction

   // Dot correction field of one channel in a frame
   function automatic lsf_pkg::lsf_dc_t dc_field(input lsf_pkg::lsf_frame_t f, input int ch);
      return f[ch*`LSF_DC_W +: `LSF_DC_W];
   endfunction

   // Status frame: overheat on top, faults below, corrections at the bottom
   function automatic lsf_pkg::lsf_frame_t build_status(
      input logic                          ot,
      input logic [`LSF_FLT_W-1:0]         flt,
      input logic [`LSF_CH*`LSF_DC_W-1:0]  dcv);
      lsf_pkg::lsf_frame_t f;
      f = '0;
      f[`LSF_ST_OT_BIT] = ot;
      f[`LSF_ST_FLT_MSB:`LSF_ST_FLT_LSB] = flt;
      f[`LSF_DC_FIELD_MSB:0] = dcv;
      return f;
   endfunction

   // Link and analog-side pins pass two flip-flops, bus pins do not
   assign sync_d = {por_i, overheat_flag_i, channel_fault_flags_i,
                    latch_in_i, shift_clock_in_i, serial_in_i};

   lsf_sync #(
      .W       (`LSF_SYNC_W)
   ) u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .d_i     (sync_d),
      .q_o     (sync_q),
      .q_dly_o ({por_s3, ot_s3, flt_s3, ld_s3, ck_s3, sd_s3})
   );

   assign {por_s2, ot_s2, flt_s2, ld_s2, ck_s2, sd_s2} = sync_q;

   // Power-on reset, from the pin or from software
   assign blocked  = por_s2 | soft_por;
   assign core_rst = rst_i | blocked;

   // Edge detection on the link, inputs ignored while blocked
   assign ck_rise = ck_s2 & ~ck_s3 & ~blocked;
   assign ld_rise = ld_s2 & ~ld_s3 & ~blocked;

   // Shift chain: parallel load on latch, else shift on clock rise
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chain <= '0;
      end else if (ld_rise) begin
         chain <= build_status(ot_s2, flt_s2, dot_correction_o);
      end else if (ck_rise) begin
         chain <= {chain[`LSF_FRAME_MSB-1:0], sd_s3};
      end
   end

   // Last stage drives the serial output, MSB leaves first
   assign serial_out_o = chain[`LSF_FRAME_MSB];

   // Forwarded clock and latch share one delay path
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shift_clock_out_o <= 1'b0;
         latch_out_o       <= 1'b0;
      end else begin
         shift_clock_out_o <= ck_s2 & ~blocked;
         latch_out_o       <= ld_s2 & ~blocked;
      end
   end

   // Command bits taken on each latch event
   always_ff @(posedge clk_i) begin
      if (core_rst) begin
         frame_type_reg_o <= 1'b0;
         light_all_o      <= 1'b0;
      end else if (ld_rise) begin
         frame_type_reg_o <= chain[`LSF_BIT_TYPE];
         light_all_o      <= chain[`LSF_BIT_LIGHT];
      end
   end

   // Per-channel fields, selected by the incoming type bit
   always_ff @(posedge clk_i) begin
      if (core_rst) begin
         for (int i = 0; i < `LSF_CH; i++) begin
            gs_q[i] <= '0;
            dc_q[i] <= '0;
         end
      end else if (ld_rise) begin
         for (int i = 0; i < `LSF_CH; i++) begin
            if (!chain[`LSF_BIT_TYPE]) begin
               gs_q[i] <= gs_field(chain, i);
            end else begin
               dc_q[i] <= dc_field(chain, i);
            end
         end
      end
   end

   // Flatten stored fields toward the sinks
   always_comb begin
      grayscale_level_o = '0;
      dot_correction_o  = '0;
      for (int i = 0; i < `LSF_CH; i++) begin
         grayscale_level_o[i*`LSF_GS_W +: `LSF_GS_W] = gs_q[i];
         dot_correction_o[i*`LSF_DC_W +: `LSF_DC_W]  = dc_q[i];
      end
   end

   // Interrupt events
   always_comb begin
      events                = '0;
      events[`LSF_EV_GS]    = ld_rise & ~chain[`LSF_BIT_TYPE];
      events[`LSF_EV_DC]    = ld_rise &  chain[`LSF_BIT_TYPE];
      events[`LSF_EV_FAULT] = |({ot_s2, flt_s2} & ~{ot_s3, flt_s3});
   end

   lsf_irq u_irq (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .event_i  (events),
      .mask_i   (irq_mask),
      .clear_i  (irq_clear),
      .status_o (irq_status),
      .irq_o    (irq_o)
   );

   // Wishbone handshake: request seen, ack one cycle later
   assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wb_wr  = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_hit;
      end
   end

   // Read of status clears exactly the bits returned
   always_comb begin
      irq_clear = '0;
      if (wb_cyc_i && wb_stb_i && wb_ack_o && !wb_we_i && wb_adr_i == `LSF_ADR_IRQ_STAT) begin
         irq_clear = wb_dat_o[`LSF_EV_W-1:0];
      end
   end

   // Writes take effect on the edge that sees ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         soft_por <= `LSF_CTRL_RST;
         irq_mask <= `LSF_MASK_RST;
      end else if (wb_wr && wb_sel_i[0]) begin
         if (wb_adr_i == `LSF_ADR_CTRL) begin
            soft_por <= wb_dat_i[`LSF_CTRL_SOFT_POR];
         end
         if (wb_adr_i == `LSF_ADR_IRQ_MASK) begin
            irq_mask <= wb_dat_i[`LSF_EV_W-1:0];
         end
      end
   end

   // Read mux, unmapped addresses read zero
   always_comb begin
      rd_word = '0;
      if (wb_adr_i[7:6] == `LSF_PAGE_GS && wb_adr_i[1:0] == 2'b00) begin
         rd_word[`LSF_GS_W-1:0] = gs_q[wb_adr_i[5:2]];
      end else if (wb_adr_i[7:6] == `LSF_PAGE_DC && wb_adr_i[1:0] == 2'b00) begin
         rd_word[`LSF_DC_W-1:0] = dc_q[wb_adr_i[5:2]];
      end else begin
         case (wb_adr_i)
            `LSF_ADR_CTRL: begin
               rd_word[`LSF_CTRL_SOFT_POR] = soft_por;
            end
            `LSF_ADR_STATE: begin
               rd_word[`LSF_FLT_W-1:0]   = flt_s2;
               rd_word[`LSF_ST_R_OT]     = ot_s2;
               rd_word[`LSF_ST_R_TYPE]   = frame_type_reg_o;
               rd_word[`LSF_ST_R_LIGHT]  = light_all_o;
               rd_word[`LSF_ST_R_BLOCK]  = blocked;
            end
            `LSF_ADR_IRQ_STAT: begin
               rd_word[`LSF_EV_W-1:0] = irq_status;
            end
            `LSF_ADR_IRQ_MASK: begin
               rd_word[`LSF_EV_W-1:0] = irq_mask;
            end
            default: begin
               rd_word = '0;
            end
         endcase
      end
   end

   // Read data registered with the ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= '0;
      end else if (wb_hit) begin
         wb_dat_o <= rd_word;
      end
   end

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_shift;
      ck_rise && !ld_rise |=> chain[0] == $past(sd_s3)
         && chain[`LSF_FRAME_MSB:1] == $past(chain[`LSF_FRAME_MSB-1:0]);
   endproperty
   a_shift: assert property (p_shift) else $error("chain did not shift");

   property p_out_quiet;
      !ck_rise && !ld_rise |=> $stable(serial_out_o);
   endproperty
   a_out_quiet: assert property (p_out_quiet) else $error("serial out moved");

   property p_gs_load;
      ld_rise && !chain[`LSF_BIT_TYPE] |=> gs_q[0] == $past(chain[`LSF_GS_W-1:0])
         && gs_q[15] == $past(gs_field(chain, 15)) && $stable(dc_q[0]);
   endproperty
   a_gs_load: assert property (p_gs_load) else $error("grayscale not loaded");

   property p_dc_load;
      ld_rise && chain[`LSF_BIT_TYPE] |=> dc_q[15] == $past(dc_field(chain, 15))
         && $stable(gs_q[0]);
   endproperty
   a_dc_load: assert property (p_dc_load) else $error("correction not loaded");

   property p_cmd;
      ld_rise |=> light_all_o == $past(chain[`LSF_BIT_LIGHT])
         && frame_type_reg_o == $past(chain[`LSF_BIT_TYPE]);
   endproperty
   a_cmd: assert property (p_cmd) else $error("command bits not latched");

   property p_status;
      ld_rise |=> chain[`LSF_ST_OT_BIT] == $past(ot_s2)
         && chain[`LSF_ST_FLT_MSB:`LSF_ST_FLT_LSB] == $past(flt_s2)
         && chain[`LSF_DC_FIELD_MSB:0] == $past(dot_correction_o);
   endproperty
   a_status: assert property (p_status) else $error("status frame wrong");

   property p_fwd;
      !blocked ##1 !blocked |-> latch_out_o == $past(ld_s2)
         && shift_clock_out_o == $past(ck_s2);
   endproperty
   a_fwd: assert property (p_fwd) else $error("forwarded pair skewed");

   property p_por;
      blocked |=> !frame_type_reg_o && !light_all_o && gs_q[3] == '0
         && dc_q[3] == '0 && $stable(chain);
   endproperty
   a_por: assert property (p_por) else $error("reset hold broken");

   property p_one_load;
      ld_s2 && ld_s3 && !ck_rise |=> $stable(chain);
   endproperty
   a_one_load: assert property (p_one_load) else $error("second load in pulse");

   property p_ack;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("ack held too long");

   c_gs:    cover property (ld_rise && !chain[`LSF_BIT_TYPE]);
   c_dc:    cover property (ld_rise && chain[`LSF_BIT_TYPE]);
   c_irq:   cover property ($rose(irq_o));
   c_shift: cover property (ck_rise ##[1:20] ck_rise);
endmodule

// ==== dv/lsf_host_model.sv ====
`timescale 1ns/100ps
`include "lsf_map.svh"
module lsf_host_model (
   // System clock, times the link pins and samples the forwarded side
   input  wire logic  clk_i,
   // Link towards the device, routed side by side
   output logic       latch_in_o,
   output logic       shift_clock_in_o,
   output logic       serial_in_o,
   // Forwarded link coming back
   input  wire logic  latch_out_i,
   input  wire logic  shift_clock_out_i,
   input  wire logic  serial_out_i
);
   logic                sco_q = 1'b0;
   logic                so_q = 1'b0;
   lsf_pkg::lsf_frame_t cap = '0;

   // Idle link: clock and latch stand low
   initial begin
      latch_in_o <= 1'b0;
      shift_clock_in_o <= 1'b0;
      serial_in_o <= 1'b0;
   end

   // Take the bit seen just before each forwarded clock rise
   always @(posedge clk_i) begin
      sco_q <= shift_clock_out_i;
      so_q <= serial_out_i;
      if (shift_clock_out_i && !sco_q) begin
         cap <= {cap[`LSF_FRAME_MSB-1:0], so_q};
      end
   end

   // One frame out, previous status in, then latch
   task automatic send_frame(input lsf_pkg::lsf_frame_t f, output lsf_pkg::lsf_frame_t st,
                             output logic lo_seen);
      // Link clock of 16 system clocks, data moves on its falling edge
      @(posedge clk_i);
      for (int i = `LSF_FRAME_MSB; i >= 0; i--) begin
         serial_in_o <= f[i];
         repeat (8) @(posedge clk_i);
         shift_clock_in_o <= 1'b1;
         repeat (8) @(posedge clk_i);
         shift_clock_in_o <= 1'b0;
      end
      repeat (8) @(posedge clk_i);
      st = cap;
      latch_in_o <= 1'b1;
      repeat (12) @(posedge clk_i);
      lo_seen = latch_out_i;
      repeat (4) @(posedge clk_i);
      latch_in_o <= 1'b0;
      serial_in_o <= ~serial_in_o;
      repeat (24) @(posedge clk_i);
   endtask
endmodule

// ==== dv/test_lsf_frame_port.sv ====
`timescale 1ns/100ps
`include "lsf_map.svh"
module test_lsf_frame_port;
   logic                                 clk_i = 1'b0;
   logic                                 rst_i = 1'b1;
   logic                                 wb_cyc_i = 1'b0;
   logic                                 wb_stb_i = 1'b0;
   logic                                 wb_we_i = 1'b0;
   logic [7:0]                           wb_adr_i = '0;
   logic [3:0]                           wb_sel_i = '0;
   logic [31:0]                          wb_dat_i = '0;
   logic [31:0]                          wb_dat_o;
   logic                                 wb_ack_o;
   logic                                 irq_o;
   logic                                 latch_in;
   logic                                 sck_in;
   logic                                 sdat_in;
   logic                                 latch_out;
   logic                                 sck_out;
   logic                                 sdat_out;
   logic                                 por_i = 1'b0;
   logic                                 ot_i = 1'b0;
   logic [`LSF_FLT_W-1:0]                flt_i = '0;
   logic                                 type_o;
   logic                                 light_o;
   logic [`LSF_CH*`LSF_GS_W-1:0]         gs_o;
   logic [`LSF_CH*`LSF_DC_W-1:0]         dc_o;
   int                                   bad_count = 0;
   int                                   total_checks = 0;
   logic [31:0]                          rd;
   lsf_pkg::lsf_frame_t                  f1, f2, f3, st, exp_st;
   logic                                 lo;
   logic                                 so_keep;

   // System clock
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end

   lsf_frame_port lsf_frame_port_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
      .latch_in_i(latch_in), .shift_clock_in_i(sck_in), .serial_in_i(sdat_in),
      .latch_out_o(latch_out), .shift_clock_out_o(sck_out), .serial_out_o(sdat_out),
      .por_i(por_i), .overheat_flag_i(ot_i), .channel_fault_flags_i(flt_i),
      .frame_type_reg_o(type_o), .light_all_o(light_o), .grayscale_level_o(gs_o),
      .dot_correction_o(dc_o));

   lsf_host_model lsf_host_model_i (.clk_i(clk_i), .latch_in_o(latch_in),
      .shift_clock_in_o(sck_in), .serial_in_o(sdat_in), .latch_out_i(latch_out),
      .shift_clock_out_i(sck_out), .serial_out_i(sdat_out));

   // Compare and count
   task automatic chk(input lsf_pkg::lsf_frame_t seen, input lsf_pkg::lsf_frame_t exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // One classic bus cycle, waits for ack, then checks its latency
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      chk(n, 2);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask

   // Frame with light, type and a per-channel pattern
   function automatic lsf_pkg::lsf_frame_t frame_of(input logic l, input logic t,
                                                    input logic [7:0] s);
      lsf_pkg::lsf_frame_t f;
      f = '0;
      f[`LSF_BIT_LIGHT] = l;
      f[`LSF_BIT_TYPE] = t;
      for (int n = 0; n < `LSF_CH; n++) begin
         if (t) f[n*6 +: 6] = s[5:0] ^ 6'(n);
         else f[n*12 +: 12] = {s, 4'(n)};
      end
      return f;
   endfunction

   task end_sim;
      if (bad_count == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Watchdog
   initial begin
      #300000;
      bad_count++;
      $display("mismatch at %0t: run timed out", $time);
      end_sim();
   end

   // Main sequence
   initial begin
      f1 = frame_of(1'b0, 1'b1, 8'h2A);
      f2 = frame_of(1'b1, 1'b0, 8'hC5);
      f3 = frame_of(1'b0, 1'b0, 8'h3E);
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(8'h00, 32'h0000_0000);
      rd_chk(8'h0C, 32'h0000_0000);
      rd_chk(8'h3C, 32'h0000_0000);
      chk(gs_o, '0);
      chk(dc_o, '0);
      lsf_host_model_i.send_frame(f1, st, lo);
      chk(lo, 1'b1);
      chk(type_o, 1'b1);
      chk(light_o, 1'b0);
      chk(dc_o, f1[95:0]);
      chk(gs_o, '0);
      @(posedge clk_i);
      ot_i <= 1'b1;
      flt_i <= 16'hA5C3;
      lsf_host_model_i.send_frame(f2, st, lo);
      chk(type_o, 1'b0);
      chk(light_o, 1'b1);
      chk(gs_o, f2[191:0]);
      chk(dc_o, f1[95:0]);
      chk(irq_o, 1'b0);
      rd_chk(8'h08, 32'h0000_0007);
      rd_chk(8'h08, 32'h0000_0000);
      rd_chk(8'h04, 32'h0005_A5C3);
      wb(1'b1, 8'h0C, 32'h0000_0001);
      rd_chk(8'h0C, 32'h0000_0001);
      exp_st = '0;
      exp_st[`LSF_ST_OT_BIT] = 1'b1;
      exp_st[`LSF_ST_FLT_MSB:`LSF_ST_FLT_LSB] = 16'hA5C3;
      exp_st[95:0] = f1[95:0];
      lsf_host_model_i.send_frame(f3, st, lo);
      chk(st, exp_st);
      chk(light_o, 1'b0);
      chk(gs_o, f3[191:0]);
      chk(irq_o, 1'b1);
      rd_chk(8'h08, 32'h0000_0001);
      repeat (2) @(posedge clk_i);
      chk(irq_o, 1'b0);
      // Blocked by the soft power-on reset
      wb(1'b1, 8'h00, 32'h0000_0001);
      repeat (6) @(posedge clk_i);
      chk(gs_o, '0);
      chk(dc_o, '0);
      rd_chk(8'h04, 32'h0009_A5C3);
      so_keep = sdat_out;
      lsf_host_model_i.send_frame(f2, st, lo);
      chk(lo, 1'b0);
      chk(gs_o, '0);
      chk(sdat_out, so_keep);
      wb(1'b1, 8'h00, 32'h0000_0000);
      rd_chk(8'h00, 32'h0000_0000);
      repeat (6) @(posedge clk_i);
      // Power-on reset pin clears settings again
      lsf_host_model_i.send_frame(f1, st, lo);
      chk(dc_o, f1[95:0]);
      @(posedge clk_i);
      por_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      chk(dc_o, '0);
      chk(type_o, 1'b0);
      por_i <= 1'b0;
      end_sim();
   end
endmodule
